// [rtl/cml_pkg.sv]
// Constants and types shared by the code memory lock and programming block.
`default_nettype none
package cml_pkg;
    // Array sizes and the erased byte value.
    localparam int CODE_AW = 15;
    localparam int ENC_AW = 6;
    localparam int ENC_BYTES = 64;
    localparam int SIG_BYTES = 4;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [2:0] LOCK_ERASED = 3'h7;
    // Mode selects packed as {a, b, c, d, e}.
    localparam logic [4:0] SEL_PROG_CODE = 5'h0F;
    localparam logic [4:0] SEL_PROG_ENC = 5'h0D;
    localparam logic [4:0] SEL_LOCK_ONE = 5'h1F;
    localparam logic [4:0] SEL_LOCK_TWO = 5'h1C;
    localparam logic [4:0] SEL_LOCK_THREE = 5'h16;
    // Read modes packed as {a, c, d, e}; select b only gates the output.
    localparam logic [3:0] SEL_VERIFY = 4'h3;
    localparam logic [3:0] SEL_SIGNATURE = 4'h0;
    // Signature locations.
    localparam logic [7:0] SIG_ADDR_0 = 8'h30;
    localparam logic [7:0] SIG_ADDR_1 = 8'h31;
    localparam logic [7:0] SIG_ADDR_2 = 8'h60;
    localparam logic [7:0] SIG_ADDR_3 = 8'h61;
    // APB register byte offsets and field positions.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CTRL_ERASE_BIT = 0;
    localparam int ST_LOCK_LSB = 0;
    localparam int ST_LEVEL_LSB = 4;
    localparam int ST_EA_BIT = 8;
    localparam int ST_SETUP_BIT = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Security levels.
    localparam logic [2:0] LEVEL_ONE = 3'h1;
    localparam logic [2:0] LEVEL_TWO = 3'h2;
    localparam logic [2:0] LEVEL_THREE = 3'h3;
    localparam logic [2:0] LEVEL_FOUR = 3'h4;

    // Setup modes decoded from the control pins.
    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_PROG_CODE,
        MODE_PROG_ENC,
        MODE_LOCK_ONE,
        MODE_LOCK_TWO,
        MODE_LOCK_THREE,
        MODE_VERIFY,
        MODE_SIGNATURE
    } cml_mode_t;
endpackage : cml_pkg
`default_nettype wire

// [rtl/cml_byte_mem.sv]
// Byte-wide erasable programmable array with bit clearing writes and erase.
`timescale 1ns/10ps
`default_nettype none
module cml_byte_mem #(
    parameter int AW = 6
) (
    // Clock and enable.
    input wire logic clock_i,
    input wire logic clk_en_i,
    // Erase and program port.
    input wire logic erase_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Read port.
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    import cml_pkg::*;

    // Cells start erased, as a blank or freshly erased part does.
    logic [7:0] mem [2**AW] = '{default: ERASED_BYTE};

    // A write can only clear bits; erase returns every cell to ones.
    always_ff @(posedge clock_i) begin
        if (clk_en_i) begin
            if (erase_i) begin
                for (int i = 0; i < 2**AW; i++) begin
                    mem[i] <= ERASED_BYTE;
                end
            end else if (we_i) begin
                mem[waddr_i] <= mem[waddr_i] & wdata_i;
            end
        end
    end

    // Read is combinational; the caller registers it.
    assign rdata_o = mem[raddr_i];
endmodule : cml_byte_mem
`default_nettype wire

// [rtl/cml_code_lock.sv]
// Program memory lock, encryption and parallel programming logic.
//
// Behaviour
// [RULE_01] Code array of 16 or 32 KB, 64-byte encryption array, 4 fixed signatures.
// [RULE_02] Encryption bytes stay all ones until programmed.
// [RULE_03] Low six address bits pick the encryption byte on verify.
// [RULE_04] Verify data is code XNOR encryption byte.
// [RULE_05] Programmer fills unused code with random values.
// [RULE_06] Level one: verify still scrambled, external code reads get plain code.
// [RULE_07] Level two: block external code reads, latch access pin, stop programming.
// [RULE_08] Level three: as level two and verify reads disabled.
// [RULE_09] Level four: as level three and no external execution.
// [RULE_10] Programmer sets levels two and three only after verification.
// [RULE_11] Setup modes need reset high, strobe low; code program and verify selects.
// [RULE_12] Encryption program and signature read selects.
// [RULE_13] Lock bit one, two, three program selects under high voltage.
// [RULE_14] Address comes from port one, port two 0..5 and port three 4.
// [RULE_15] Data travels on port zero, bits D0 to D7.
// [RULE_16] Programmer sets mode, address, data, voltage, one pulse, per byte.
// [RULE_17] One programming pulse programs a byte completely.
// [RULE_18] Read data drives port zero only while select b enables it.
// [RULE_19] Programmer verifies code after each byte or block.
// [RULE_20] Encryption contents have no direct read path.
// [RULE_21] Signatures at 30h, 31h, 60h, 61h under signature mode.
// [RULE_22] Erase sets code, encryption and lock bits to ones; a lock pulse in the erase cycle still programs its bit.
// [RULE_23] Any lock bit mix counts as the highest level shown.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cml_code_lock #(
    parameter int CODE_AW = cml_pkg::CODE_AW,
    parameter logic [7:0] SIG_BYTE_0 = 8'hA5, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE_1 = 8'h5A, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE_2 = 8'h3C, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE_3 = 8'hC3 // Arbitrary value.
) (
    // Clock, reset and enable.
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // Programming control pins.
    input wire logic reset_pin_i,
    input wire logic program_store_strobe_n_i,
    input wire logic latch_or_program_pulse_n_i,
    input wire logic program_voltage_high_i,
    input wire logic external_access_pin_n_i,
    input wire logic mode_select_a_i,
    input wire logic mode_select_b_i,
    input wire logic mode_select_c_i,
    input wire logic mode_select_d_i,
    input wire logic mode_select_e_i,
    // Address and data pins.
    input wire logic [7:0] port_one_i,
    input wire logic [5:0] port_two_i,
    input wire logic port_three_4_i,
    input wire logic [7:0] port_zero_i,
    output logic [7:0] port_zero_o,
    output logic port_zero_oe_o,
    // Core code read instruction port.
    input wire logic core_rd_req_i,
    input wire logic core_rd_external_i,
    input wire logic [14:0] core_rd_addr_i,
    output logic [7:0] core_rd_data_o,
    output logic core_rd_blocked_o,
    // Core access control.
    output logic external_access_n_o,
    output logic external_exec_en_o,
    output logic [2:0] security_level_o,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import cml_pkg::*;

    // Security level from active-low lock bits, highest one wins.
    function automatic logic [2:0] level_of(input logic [2:0] lock_n);
        if (!lock_n[2]) begin
            return LEVEL_FOUR;
        end else if (!lock_n[1]) begin
            return LEVEL_THREE;
        end else if (!lock_n[0]) begin
            return LEVEL_TWO;
        end
        return LEVEL_ONE;
    endfunction : level_of

    // Setup mode from pin levels.
    function automatic cml_mode_t mode_of(input logic rst, input logic program_store_strobe_n,
                                          input logic ale, input logic vpp,
                                          input logic [4:0] sel);
        logic [3:0] rsel;
        rsel = {sel[4], sel[2:0]};
        if (!rst || program_store_strobe_n) begin
            return MODE_IDLE;
        end else if (vpp) begin
            case (sel)
                SEL_PROG_CODE: return MODE_PROG_CODE;
                SEL_PROG_ENC: return MODE_PROG_ENC;
                SEL_LOCK_ONE: return MODE_LOCK_ONE;
                SEL_LOCK_TWO: return MODE_LOCK_TWO;
                SEL_LOCK_THREE: return MODE_LOCK_THREE;
                default: return MODE_IDLE;
            endcase
        end else if (ale && rsel == SEL_VERIFY) begin
            return MODE_VERIFY;
        end else if (ale && rsel == SEL_SIGNATURE) begin
            return MODE_SIGNATURE;
        end
        return MODE_IDLE;
    endfunction : mode_of

    cml_mode_t mode;
    logic [4:0] sel;
    logic [14:0] pin_addr;
    logic [2:0] lock_n = LOCK_ERASED; // Nonvolatile: starts erased.
    logic [2:0] level;
    logic pulse_prev;
    logic pulse_fall;
    logic code_we;
    logic enc_we;
    logic erase;
    logic ea_latched;
    logic [CODE_AW-1:0] code_raddr;
    logic [7:0] code_rd;
    logic [7:0] enc_rd;
    logic [7:0] sig_byte;
    logic [31:0] next_prdata;
    logic apb_setup;
    logic apb_write;

    // Pin address and selects.
    assign pin_addr = {port_three_4_i, port_two_i, port_one_i}; // RULE_14
    assign sel = {mode_select_a_i, mode_select_b_i, mode_select_c_i,
                  mode_select_d_i, mode_select_e_i};
    // Mode decode for every setup mode.
    assign mode = mode_of(reset_pin_i, program_store_strobe_n_i, // RULE_11
                          latch_or_program_pulse_n_i, program_voltage_high_i,
                          sel); // RULE_12 RULE_13
    assign level = level_of(lock_n); // RULE_23
    assign security_level_o = level;

    // Programming pulse edge detector.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_prev <= 1'b1;
        end else if (clk_en_i) begin
            pulse_prev <= latch_or_program_pulse_n_i;
        end
    end

    // One falling pulse edge writes the byte in full.
    assign pulse_fall = pulse_prev & ~latch_or_program_pulse_n_i; // RULE_17
    // Array writes are refused once any lock bit is programmed.
    assign code_we = pulse_fall && mode == MODE_PROG_CODE &&
                     level == LEVEL_ONE; // RULE_07
    assign enc_we = pulse_fall && mode == MODE_PROG_ENC &&
                    level == LEVEL_ONE; // RULE_07

    // Code address: programmer pins in setup modes, else the core.
    assign code_raddr = (mode != MODE_IDLE) ?
                        pin_addr[CODE_AW-1:0] : core_rd_addr_i[CODE_AW-1:0];

    // Code array, sized by the part variant.
    cml_byte_mem #(
        .AW(CODE_AW) // RULE_01
    ) u_code_mem (
        .clock_i(clock_i),
        .clk_en_i(clk_en_i),
        .erase_i(erase), // RULE_22
        .we_i(code_we),
        .waddr_i(pin_addr[CODE_AW-1:0]),
        .wdata_i(port_zero_i), // RULE_15
        .raddr_i(code_raddr),
        .rdata_o(code_rd)
    );

    // Encryption array, indexed by the low six address bits only.
    cml_byte_mem #(
        .AW(ENC_AW) // RULE_01
    ) u_enc_mem (
        .clock_i(clock_i),
        .clk_en_i(clk_en_i),
        .erase_i(erase), // RULE_02
        .we_i(enc_we),
        .waddr_i(pin_addr[ENC_AW-1:0]),
        .wdata_i(port_zero_i),
        .raddr_i(pin_addr[ENC_AW-1:0]), // RULE_03
        .rdata_o(enc_rd)
    );

    // Lock bits have no reset; a pulse in an erase cycle still programs.
    always_ff @(posedge clock_i) begin
        if (clk_en_i) begin
            if (erase) begin
                lock_n <= LOCK_ERASED; // RULE_22
            end
            if (pulse_fall) begin
                case (mode)
                    MODE_LOCK_ONE: lock_n[0] <= 1'b0; // RULE_13
                    MODE_LOCK_TWO: lock_n[1] <= 1'b0;
                    MODE_LOCK_THREE: lock_n[2] <= 1'b0;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Access pin follows the pin during reset and is frozen after it.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ea_latched <= 1'b1;
        end else if (clk_en_i && reset_pin_i) begin
            ea_latched <= external_access_pin_n_i;
        end
    end

    // Latched level applies from level two upward.
    assign external_access_n_o = (level >= LEVEL_TWO) ?
                                 ea_latched : external_access_pin_n_i; // RULE_07
    assign external_exec_en_o = level != LEVEL_FOUR; // RULE_09

    // Signature lookup; other addresses read as ones.
    always_comb begin
        case (pin_addr[7:0])
            SIG_ADDR_0: sig_byte = SIG_BYTE_0; // RULE_21
            SIG_ADDR_1: sig_byte = SIG_BYTE_1;
            SIG_ADDR_2: sig_byte = SIG_BYTE_2;
            SIG_ADDR_3: sig_byte = SIG_BYTE_3;
            default: sig_byte = ERASED_BYTE;
        endcase
    end

    // Verify data register; encryption bytes only ever leave scrambled.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_zero_o <= ERASED_BYTE;
        end else if (clk_en_i) begin
            if (mode == MODE_VERIFY && level < LEVEL_THREE) begin
                port_zero_o <= ~(code_rd ^ enc_rd); // RULE_04 RULE_06 RULE_20
            end else if (mode == MODE_SIGNATURE) begin
                port_zero_o <= sig_byte; // RULE_21
            end
        end
    end

    // Output enable needs select b and a permitted read mode.
    assign port_zero_oe_o = mode_select_b_i && // RULE_18
                            ((mode == MODE_VERIFY && level < LEVEL_THREE) ||
                             mode == MODE_SIGNATURE); // RULE_08

    // Core code reads from external memory are blocked from level two.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_rd_data_o <= ERASED_BYTE;
            core_rd_blocked_o <= 1'b0;
        end else if (clk_en_i && core_rd_req_i) begin
            if (core_rd_external_i && level >= LEVEL_TWO) begin
                core_rd_data_o <= ERASED_BYTE; // RULE_07 RULE_08 RULE_09
                core_rd_blocked_o <= 1'b1;
            end else begin
                core_rd_data_o <= code_rd; // RULE_06
                core_rd_blocked_o <= 1'b0;
            end
        end
    end

    // APB decode: zero wait states, error on unmapped offsets.
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i;
    assign pready_o = psel_i && penable_i;
    assign pslverr_o = pready_o && paddr_i != REG_CTRL &&
                       paddr_i != REG_STATUS;
    // Writing the erase bit wipes arrays and any lock bit not pulsed in that same cycle.
    assign erase = clk_en_i && apb_write && paddr_i == REG_CTRL &&
                   pwdata_i[CTRL_ERASE_BIT]; // RULE_22

    // Read data is prepared in the setup cycle.
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr_i == REG_STATUS) begin
            next_prdata[ST_LOCK_LSB +: 3] = lock_n;
            next_prdata[ST_LEVEL_LSB +: 3] = level;
            next_prdata[ST_EA_BIT] = ea_latched;
            next_prdata[ST_SETUP_BIT] = mode != MODE_IDLE;
        end
    end

    // Read data register.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= CTRL_RESET;
        end else if (clk_en_i && apb_setup) begin
            prdata_o <= next_prdata;
        end
    end

    // Verify data is the XNOR of the two arrays one cycle later.
    a_verify_xnor: assert property (@(posedge clock_i) // RULE_04
        disable iff (!arst_n_i)
        (clk_en_i && mode == MODE_VERIFY && level < LEVEL_THREE) |=>
        port_zero_o == ~($past(code_rd) ^ $past(enc_rd)))
        else $error("verify data is not code xnor encryption byte");

    // Port zero is driven only with select b high.
    a_oe_select_b: assert property (@(posedge clock_i) // RULE_18
        disable iff (!arst_n_i) port_zero_oe_o |-> mode_select_b_i)
        else $error("port zero driven without select b");

    // Verify output stays off from level three.
    a_verify_disabled: assert property (@(posedge clock_i) // RULE_08
        disable iff (!arst_n_i)
        (mode == MODE_VERIFY && level >= LEVEL_THREE) |-> !port_zero_oe_o)
        else $error("verify output at level three or above");

    // Blocked external code reads return ones and flag it.
    a_core_blocked: assert property (@(posedge clock_i) // RULE_07
        disable iff (!arst_n_i)
        (clk_en_i && core_rd_req_i && core_rd_external_i &&
         level >= LEVEL_TWO) |=>
        core_rd_blocked_o && core_rd_data_o == ERASED_BYTE)
        else $error("external code read not blocked");

    // Level one gives plain code to external code reads.
    a_core_plain: assert property (@(posedge clock_i) // RULE_06
        disable iff (!arst_n_i)
        (clk_en_i && core_rd_req_i && level == LEVEL_ONE) |=>
        !core_rd_blocked_o && core_rd_data_o == $past(code_rd))
        else $error("level one code read altered");

    // No array writes once locked.
    a_no_locked_prog: assert property (@(posedge clock_i) // RULE_07
        disable iff (!arst_n_i)
        level != LEVEL_ONE |-> !code_we && !enc_we)
        else $error("array programmed while locked");

    // Lock bits return to ones only through erase.
    a_lock_only_erase: assert property (@(posedge clock_i) // RULE_23
        disable iff (!arst_n_i)
        !$past(erase) |-> (lock_n & ~$past(lock_n)) == 3'h0)
        else $error("lock bit cleared without erase");

    // Level four forbids external execution and follows lock bit three.
    a_level_four: assert property (@(posedge clock_i) // RULE_09
        disable iff (!arst_n_i)
        !lock_n[2] |-> level == LEVEL_FOUR && !external_exec_en_o)
        else $error("lock bit three did not reach level four");

    // Signature byte two at 60h appears on the data register one cycle later.
    a_sig_read: assert property (@(posedge clock_i) // RULE_21
        disable iff (!arst_n_i)
        (clk_en_i && mode == MODE_SIGNATURE &&
         pin_addr[7:0] == SIG_ADDR_2) |=> port_zero_o == SIG_BYTE_2)
        else $error("signature byte mismatch");

    // The latched access level holds outside reset.
    a_ea_hold: assert property (@(posedge clock_i) // RULE_07
        disable iff (!arst_n_i)
        (!$past(reset_pin_i) && level >= LEVEL_TWO) |->
        $stable(ea_latched) && external_access_n_o == ea_latched)
        else $error("latched access pin changed");
endmodule : cml_code_lock
`default_nettype wire

// [verif/cml_programmer.sv]
// Parallel programmer model that drives the setup pins of the lock block.
`timescale 1ns/10ps
`default_nettype none
module cml_programmer (
    // Clock.
    input wire logic clock_i,
    // Pins toward the device.
    output logic rst_pin_o,
    output logic strobe_n_o,
    output logic pulse_n_o,
    output logic vpp_o,
    output logic ea_n_o,
    output logic [4:0] sel_o,
    output logic [14:0] addr_o,
    output logic [7:0] data_o,
    // Data port wire level and device drive enable.
    input wire logic [7:0] bus_i,
    input wire logic oe_i
);
    // Idle levels: reset high, strobe low, no mode decoded.
    initial begin
        rst_pin_o = 1'b1;
        strobe_n_o = 1'b0;
        pulse_n_o = 1'b1;
        vpp_o = 1'b0;
        ea_n_o = 1'b1;
        sel_o = 5'h1F;
        addr_o = '0;
        data_o = 8'h00;
    end

    // Writes one byte with one pulse under raised voltage.
    task automatic write_byte(input logic [4:0] s, input logic [14:0] a,
                              input logic [7:0] d);
        @(posedge clock_i);
        sel_o <= s;
        addr_o <= a;
        data_o <= d;
        vpp_o <= 1'b1;
        @(posedge clock_i);
        pulse_n_o <= 1'b0;
        @(posedge clock_i);
        pulse_n_o <= 1'b1;
        @(posedge clock_i);
        vpp_o <= 1'b0;
        data_o <= ~d; // A released line must not keep its last value.
        sel_o <= 5'h1F;
    endtask : write_byte

    // Reads one byte in a read mode; returns {enable, wire level}.
    task automatic read_byte(input logic [3:0] s, input logic b,
                             input logic [14:0] a, output logic [8:0] r);
        @(posedge clock_i);
        sel_o <= {s[3], b, s[2:0]};
        addr_o <= a;
        @(posedge clock_i);
        @(negedge clock_i);
        r = {oe_i, bus_i};
        @(posedge clock_i);
        sel_o <= 5'h1F;
    endtask : read_byte

    // Sets the reset and access pin levels.
    task automatic set_pins(input logic rst, input logic ea_n);
        @(posedge clock_i);
        rst_pin_o <= rst;
        ea_n_o <= ea_n;
    endtask : set_pins
endmodule : cml_programmer
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the code memory lock block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cml_pkg::*;
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] code;
        logic [7:0] enc;
        logic [7:0] vfy;
    } cml_row_t;
    // Code byte, encryption byte (FF = left erased), expected verify.
    localparam cml_row_t ROWS [4] = '{
        '{15'h0001, 8'h3C, 8'hFF, 8'h3C},
        '{15'h4042, 8'hA5, 8'h0F, 8'h55},
        '{15'h2003, 8'h00, 8'hF0, 8'h0F},
        '{15'h7FFF, 8'h81, 8'h7E, 8'h00}};
    // Signature values are arbitrary; the last place holds none.
    localparam logic [7:0] SIGV [5] = '{8'h11, 8'h22, 8'h44, 8'h88, 8'hFF};
    localparam logic [14:0] SIGA [5] = '{15'h30, 15'h31, 15'h60, 15'h61,
                                         15'h01};
    logic clock_i, arst_n_i, rst_pin, strobe_n, pulse_n, vpp, ea_n;
    logic [4:0] sel;
    logic [14:0] addr, core_addr;
    logic [7:0] pdata, p0_o, p0_wire, core_data, paddr;
    logic p0_oe, core_blk, ea_eff, exec_en, core_req, core_ext;
    logic [2:0] level;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata;
    int error_cnt, comparisons;

    // The data wire carries whichever party enables its drive.
    assign p0_wire = p0_oe ? p0_o : pdata;

    cml_code_lock #(.CODE_AW(15), .SIG_BYTE_0(SIGV[0]), .SIG_BYTE_1(SIGV[1]),
        .SIG_BYTE_2(SIGV[2]), .SIG_BYTE_3(SIGV[3])) dut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
        .reset_pin_i(rst_pin), .program_store_strobe_n_i(strobe_n),
        .latch_or_program_pulse_n_i(pulse_n), .program_voltage_high_i(vpp),
        .external_access_pin_n_i(ea_n), .mode_select_a_i(sel[4]),
        .mode_select_b_i(sel[3]), .mode_select_c_i(sel[2]),
        .mode_select_d_i(sel[1]), .mode_select_e_i(sel[0]),
        .port_one_i(addr[7:0]), .port_two_i(addr[13:8]),
        .port_three_4_i(addr[14]), .port_zero_i(p0_wire),
        .port_zero_o(p0_o), .port_zero_oe_o(p0_oe),
        .core_rd_req_i(core_req), .core_rd_external_i(core_ext),
        .core_rd_addr_i(core_addr), .core_rd_data_o(core_data),
        .core_rd_blocked_o(core_blk), .external_access_n_o(ea_eff),
        .external_exec_en_o(exec_en), .security_level_o(level),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr));

    cml_programmer pgm (.clock_i(clock_i), .rst_pin_o(rst_pin),
        .strobe_n_o(strobe_n), .pulse_n_o(pulse_n), .vpp_o(vpp),
        .ea_n_o(ea_n), .sel_o(sel), .addr_o(addr), .data_o(pdata),
        .bus_i(p0_wire), .oe_i(p0_oe));

    // Clock at 25 MHz.
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Compares a seen value with the expected one and counts both.
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; returns {pslverr, prdata}.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [32:0] r);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One core code read; returns {blocked, data}.
    task automatic core_rd(input logic ext, input logic [14:0] a,
                           output logic [8:0] r);
        @(posedge clock_i);
        core_req <= 1'b1;
        core_ext <= ext;
        core_addr <= a;
        @(posedge clock_i);
        core_req <= 1'b0;
        @(negedge clock_i);
        r = {core_blk, core_data};
    endtask : core_rd

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // Watchdog against a hang.
    initial begin
        #(40 * 3000);
        error_cnt++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        logic [8:0] r;
        logic [32:0] b;
        arst_n_i = 1'b0;
        core_req = 1'b0;
        core_ext = 1'b0;
        core_addr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        error_cnt = 0;
        comparisons = 0;
        repeat (6) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(negedge clock_i);
        chk({p0_o, core_data, core_blk}, {8'hFF, 8'hFF, 1'b0});
        chk(level, LEVEL_ONE);
        apb(1'b0, REG_STATUS, 32'h0, b);
        chk(b, 33'h0_0000_0117);
        apb(1'b0, REG_CTRL, 32'h0, b);
        chk(b, {1'b0, CTRL_RESET});
        apb(1'b0, 8'h08, 32'h0, b);
        chk(b, 33'h1_0000_0000);
        // Ordinary cases: program, verify scrambled, core read plain.
        foreach (ROWS[i]) begin
            pgm.write_byte(SEL_PROG_CODE, ROWS[i].addr, ROWS[i].code);
            if (ROWS[i].enc != 8'hFF)
                pgm.write_byte(SEL_PROG_ENC, ROWS[i].addr, ROWS[i].enc);
            pgm.read_byte(SEL_VERIFY, 1'b1, ROWS[i].addr, r);
            chk(r, {1'b1, ROWS[i].vfy});
            core_rd(1'b1, ROWS[i].addr, r);
            chk(r, {1'b0, ROWS[i].code});
        end
        pgm.read_byte(SEL_VERIFY, 1'b0, ROWS[0].addr, r);
        chk(r[8], 1'b0);
        foreach (SIGA[i]) begin
            pgm.read_byte(SEL_SIGNATURE, 1'b1, SIGA[i], r);
            chk(r, {1'b1, SIGV[i]});
        end
        // Level two: external reads blocked, programming refused.
        pgm.write_byte(SEL_LOCK_ONE, 15'h0, 8'h00);
        @(negedge clock_i);
        chk(level, LEVEL_TWO);
        core_rd(1'b1, ROWS[0].addr, r);
        chk(r, 9'h1FF);
        pgm.write_byte(SEL_PROG_CODE, ROWS[0].addr, 8'h00);
        pgm.read_byte(SEL_VERIFY, 1'b1, ROWS[0].addr, r);
        chk(r, {1'b1, ROWS[0].vfy});
        pgm.set_pins(1'b0, 1'b1);
        pgm.set_pins(1'b0, 1'b0);
        @(negedge clock_i);
        chk(ea_eff, 1'b1);
        pgm.read_byte(SEL_VERIFY, 1'b1, ROWS[0].addr, r);
        chk(r[8], 1'b0);
        pgm.set_pins(1'b1, 1'b1);
        // Lock bits survive a reset of the logic.
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(negedge clock_i);
        chk(level, LEVEL_TWO);
        // Level three with two bits set: verify disabled.
        pgm.write_byte(SEL_LOCK_TWO, 15'h0, 8'h00);
        @(negedge clock_i);
        chk(level, LEVEL_THREE);
        pgm.read_byte(SEL_VERIFY, 1'b1, ROWS[1].addr, r);
        chk(r[8], 1'b0);
        core_rd(1'b1, ROWS[1].addr, r);
        chk(r[8], 1'b1);
        // Level four: external execution off.
        pgm.write_byte(SEL_LOCK_THREE, 15'h0, 8'h00);
        @(negedge clock_i);
        chk({level, exec_en}, {LEVEL_FOUR, 1'b0});
        apb(1'b0, REG_STATUS, 32'h0, b);
        chk(b, 33'h0_0000_0140);
        // Erase restores level one and all-ones contents.
        apb(1'b1, REG_CTRL, 32'h1, b);
        @(negedge clock_i);
        chk({level, exec_en}, {LEVEL_ONE, 1'b1});
        pgm.read_byte(SEL_VERIFY, 1'b1, ROWS[1].addr, r);
        chk(r, 9'h1FF);
        core_rd(1'b1, ROWS[2].addr, r);
        chk(r, 9'h0FF);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
